// File: verilog/ptc_channel.sv
// PCI target pass-through channel with write and read FIFOs.
// Assumes PCI runs on i_clock; add-on pins are slow and asynchronous.
//
// The implementer's own choices: the register offsets and register access over Avalon-MM.
`include "ptc_defines.svh"

// ----------------------------------------
// Flip-flop FIFO, depth a power of two
// ----------------------------------------
module ptc_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_ce,
	input  wire logic                   i_push,
	input  wire logic                   i_pop,
	input  wire logic                   i_flush,
	input  wire logic [W-1:0]           i_data,
	output logic      [W-1:0]           o_data,
	output logic      [$clog2(D+1)-1:0] o_count
);
	localparam int AW = $clog2(D);
	localparam int CW = $clog2(D+1);
	localparam logic [CW-1:0] FULL = CW'(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] rp;
	logic [AW-1:0] wp;
	logic          do_push;
	logic          do_pop;
	assign do_push = i_push && (o_count != FULL);
	assign do_pop  = i_pop && (o_count != '0);
	assign o_data  = mem[rp];
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rp      <= '0;
			wp      <= '0;
			o_count <= '0;
		end else if (i_ce) begin
			if (i_flush) begin
				rp      <= '0;
				wp      <= '0;
				o_count <= '0;
			end else begin
				if (do_push)
					wp <= wp + 1'b1;
				if (do_pop)
					rp <= rp + 1'b1;
				if (do_push && !do_pop)
					o_count <= o_count + 1'b1;
				else if (do_pop && !do_push)
					o_count <= o_count - 1'b1;
			end
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_ce && do_push && !i_flush)
			mem[wp] <= i_data;
	end
endmodule

// ----------------------------------------
// Channel top
// ----------------------------------------
module ptc_channel #(
	parameter int DEPTH = 8
) (
	// Clock, reset, enable
	input  wire logic                     i_clock,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_clk_en,
	// Avalon-MM register slave
	input  wire logic [5:0]               i_avs_address,
	input  wire logic                     i_avs_read,
	input  wire logic                     i_avs_write,
	input  wire logic [31:0]              i_avs_writedata,
	output logic      [31:0]              o_avs_readdata,
	output logic                          o_avs_waitrequest,
	// PCI target
	input  wire ptc_pkg::ptc_pci_in_t     i_pci,
	output ptc_pkg::ptc_pci_out_t         o_pci,
	// Add-on bus
	input  wire logic                     i_local_clock,
	input  wire logic                     i_operating_mode_strap,
	input  wire logic                     i_chip_select_n,
	input  wire logic                     i_fetch_n,
	input  wire logic                     i_store_n,
	input  wire logic [4:0]               i_reg_index,
	input  wire logic                     i_transfer_done_n,
	input  wire logic [31:0]              i_addon_data,
	input  wire logic                     i_address_out_enable_n,
	output ptc_pkg::ptc_status_t          o_status,
	output logic      [31:0]              o_addon_data,
	output logic                          o_addon_data_oe_n
);
	import ptc_pkg::*;
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam int SW = $bits(ptc_addon_in_t);
	localparam logic [SW-1:0] SRST = `PTC_SYNC_RST;

	ptc_state_t    st;
	ptc_addon_in_t ai;
	ptc_addon_in_t ai_q;
	ptc_wentry_t   wf_head;
	logic [SW-1:0] raw;
	logic [SW-1:0] s1;
	logic [SW-1:0] s2;
	logic [SW-1:0] s3;
	logic [SW-1:0] filt;
	logic [31:0]   base [4];
	logic [31:0]   mask [4];
	logic [11:0]   ctrl;
	logic [31:0]   chan_addr;
	logic [31:0]   dq_out;
	logic [31:0]   rd_mux;
	logic [31:0]   rf_head;
	logic [31:0]   cur_mask;
	logic [31:0]   next_addr;
	logic [3:0]    hit;
	logic [3:0]    rd_be;
	logic [3:0]    fetch_left;
	logic [3:0]    tgt;
	logic [4:0]    wait_cnt;
	logic [1:0]    region;
	logic [1:0]    hit_num;
	logic [1:0]    pf_code;
	logic [2:0]    strap_cnt;
	logic [CW-1:0] wf_count;
	logic [CW-1:0] rf_count;
	logic          frame_q;
	logic          lc_prev;
	logic          passive;
	logic          first;
	logic          dq_oe_n;
	logic          lc_rise;
	logic          accept;
	logic          go_flush;
	logic          rd_done;
	logic          wr_done;
	logic          near_end;
	logic          need_fetch;
	logic          ad_fetch;
	logic          ad_addr;
	logic          ad_store;
	logic          act_go;
	logic          act_wr;
	logic          act_rd;
	logic          push_r;
	logic          pop_w;
	logic          inc;
	logic          busy;

	// ----------------------------------------
	// Add-on input synchronisers
	// ----------------------------------------
	assign raw = {i_local_clock, i_operating_mode_strap, i_chip_select_n, i_fetch_n, i_store_n,
		i_reg_index, i_transfer_done_n, i_addon_data};
	generate
		for (genvar b = 0; b < SW; b++) begin : g_sync
			always_ff @(posedge i_clock or negedge i_rst_n) begin
				if (!i_rst_n) begin
					s1[b]   <= SRST[b];
					s2[b]   <= SRST[b];
					s3[b]   <= SRST[b];
					filt[b] <= SRST[b];
				end else if (i_clk_en) begin
					s1[b] <= raw[b];
					s2[b] <= s1[b];
					s3[b] <= s2[b];
					if (s2[b] == s3[b])
						filt[b] <= s3[b];
				end
			end
		end
	endgenerate
	assign ai = filt;

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lc_prev   <= 1'b0;
			ai_q      <= SRST;
			strap_cnt <= '0;
			passive   <= 1'b1;
		end else if (i_clk_en) begin
			lc_prev <= ai.lclk;
			// Pin levels as they stood just before a local edge
			ai_q    <= ai;
			if (strap_cnt != `PTC_STRAP_WAIT) begin
				strap_cnt <= strap_cnt + 1'b1;
				passive   <= ai.strap;
			end
		end
	end

	// ----------------------------------------
	// Region decode and add-on events
	// ----------------------------------------
	generate
		for (genvar r = 0; r < 4; r++) begin : g_hit
			assign hit[r] = ctrl[8+r] && ((i_pci.ad & ~mask[r]) == base[r]);
		end
	endgenerate
	always_comb begin
		hit_num = 2'h0;
		for (int r = 3; r >= 0; r--)
			if (hit[r])
				hit_num = 2'(r);
	end
	assign cur_mask = mask[region];
	assign pf_code  = ctrl[2*region +: 2];
	assign next_addr = chan_addr + `PTC_STEP;
	assign near_end = (cur_mask - (chan_addr & cur_mask)) < `PTC_NEAR_END;
	always_comb begin
		case (pf_code)
			2'h1: tgt = 4'h2;
			2'h2: tgt = 4'h4;
			2'h3: tgt = 4'h8;
			default: tgt = 4'h1;
		endcase
	end
	assign lc_rise  = ai.lclk && !lc_prev;
	assign ad_fetch = lc_rise && passive && !ai_q.cs_n && !ai_q.fetch_n && ai_q.idx == `PTC_IDX_DATA;
	assign ad_addr  = lc_rise && passive && !ai_q.cs_n && !ai_q.fetch_n && ai_q.idx == `PTC_IDX_ADDR;
	assign ad_store = lc_rise && passive && !ai_q.cs_n && !ai_q.store_n && ai_q.idx == `PTC_IDX_DATA;
	assign act_go   = lc_rise && !passive && ai_q.done_n;
	assign act_wr   = act_go && wf_count != '0;
	assign act_rd   = act_go && wf_count == '0 && need_fetch;
	assign push_r   = (ad_store || act_rd) && rf_count != FULL;
	assign pop_w    = (ad_fetch || act_wr) && wf_count != '0;
	assign need_fetch = fetch_left != '0 && rf_count != FULL;
	assign busy     = !o_status.strobe_n || !ai.store_n;
	assign accept   = st == PTC_IDLE && !i_pci.frame_n && frame_q && hit != '0 &&
		(i_pci.cbe_n[3:1] == `PTC_CMD_IO || i_pci.cbe_n[3:1] == `PTC_CMD_MEM);
	assign go_flush = accept && !i_pci.cbe_n[0] && wf_count == '0 &&
		!((fetch_left != '0 || rf_count != '0) && i_pci.ad == chan_addr);
	assign rd_done  = st == PTC_RD && !o_pci.trdy_n && !i_pci.irdy_n;
	assign wr_done  = st == PTC_WR && !o_pci.trdy_n && !i_pci.irdy_n;
	assign inc = rd_done && ((pf_code != 2'h0 && !near_end) || !i_pci.frame_n) && fetch_left < tgt;

	// ----------------------------------------
	// FIFOs
	// ----------------------------------------
	ptc_fifo #(.W($bits(ptc_wentry_t)), .D(DEPTH)) u_wfifo (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_ce    (i_clk_en),
		.i_push  (wr_done),
		.i_pop   (pop_w),
		.i_flush (1'b0),
		.i_data  ({i_pci.cbe_n, i_pci.ad}),
		.o_data  (wf_head),
		.o_count (wf_count)
	);
	ptc_fifo #(.W(32), .D(DEPTH)) u_rfifo (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_ce    (i_clk_en),
		.i_push  (push_r),
		.i_pop   (rd_done),
		.i_flush (st == PTC_FLUSH || (accept && i_pci.cbe_n[0])),
		.i_data  (ai_q.data),
		.o_data  (rf_head),
		.o_count (rf_count)
	);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			fetch_left <= '0;
		else if (i_clk_en) begin
			if (st == PTC_FLUSH)
				fetch_left <= (pf_code == 2'h0 || near_end) ? 4'h1 : tgt;
			else if ((accept && i_pci.cbe_n[0]) || (lc_rise && passive && !ai_q.done_n))
				fetch_left <= '0;
			else
				fetch_left <= fetch_left + {3'h0, inc} - {3'h0, push_r};
		end
	end

	// ----------------------------------------
	// PCI target state machine
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st        <= PTC_IDLE;
			o_pci     <= '1;
			frame_q   <= 1'b1;
			chan_addr <= '0;
			region    <= '0;
			rd_be     <= '0;
			first     <= 1'b0;
			wait_cnt  <= '0;
		end else if (i_clk_en) begin
			frame_q <= i_pci.frame_n;
			case (st)
				PTC_IDLE: begin
					o_pci <= '1;
					if (accept) begin
						o_pci.devsel_n <= 1'b0;
						o_pci.ctl_oe_n <= 1'b0;
						chan_addr      <= i_pci.ad;
						region         <= hit_num;
						first          <= 1'b1;
						wait_cnt       <= '0;
						if (i_pci.cbe_n[0]) begin
							if (wf_count != FULL && (wf_count == '0 || i_pci.ad == chan_addr)) begin
								st           <= PTC_WR;
								o_pci.trdy_n <= 1'b0;
							end else
								st <= PTC_STOP;
						end else if (wf_count != '0)
							st <= PTC_STOP;
						else if (go_flush)
							st <= PTC_FLUSH;
						else
							st <= PTC_RD;
					end
				end
				PTC_FLUSH: begin
					rd_be <= i_pci.cbe_n;
					if (!busy)
						st <= PTC_RD;
				end
				PTC_WR: begin
					if (wr_done) begin
						chan_addr <= next_addr;
						if (i_pci.frame_n) begin
							st           <= PTC_TURN;
							o_pci.trdy_n <= 1'b1;
						end else if (wf_count >= FULL - 1'b1 || (next_addr & ~cur_mask) != base[region]) begin
							st           <= PTC_STOP;
							o_pci.trdy_n <= 1'b1;
						end
					end
				end
				PTC_RD: begin
					o_pci.ad_oe_n <= 1'b0;
					if (rd_done) begin
						chan_addr    <= next_addr;
						first        <= 1'b0;
						wait_cnt     <= '0;
						o_pci.trdy_n <= 1'b1;
						if (i_pci.frame_n)
							st <= PTC_TURN;
						else if ((next_addr & ~cur_mask) != base[region])
							st <= PTC_STOP;
					end else if (o_pci.trdy_n) begin
						if (rf_count != '0) begin
							o_pci.trdy_n <= 1'b0;
							o_pci.ad     <= rf_head;
						end else if (wait_cnt == (first ? `PTC_FIRST_WAIT : `PTC_NEXT_WAIT) - 1'b1)
							st <= PTC_STOP;
						else
							wait_cnt <= wait_cnt + 1'b1;
					end
				end
				PTC_STOP: begin
					o_pci.trdy_n  <= 1'b1;
					o_pci.ad_oe_n <= 1'b1;
					o_pci.stop_n  <= 1'b0;
					if (i_pci.frame_n)
						st <= PTC_TURN;
				end
				default: begin
					o_pci.devsel_n <= 1'b1;
					o_pci.trdy_n   <= 1'b1;
					o_pci.stop_n   <= 1'b1;
					o_pci.ad_oe_n  <= 1'b1;
					st             <= PTC_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Add-on status and data
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			o_status <= '1;
		else if (i_clk_en) begin
			o_status.attention_n  <= !(wf_count != '0 || need_fetch);
			o_status.direction    <= wf_count != '0;
			o_status.region       <= region;
			o_status.byte_valid_n <= wf_count != '0 ? wf_head.be_n : (first ? rd_be : 4'h0);
			o_status.burst_n <= !(((st == PTC_RD || st == PTC_WR) && !i_pci.frame_n) || fetch_left > 4'h1);
			if (lc_rise)
				o_status.strobe_n <= !(act_wr || act_rd);
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dq_out  <= '0;
			dq_oe_n <= 1'b1;
		end else if (i_clk_en && lc_rise) begin
			dq_oe_n <= !(ad_fetch || ad_addr || act_wr);
			if (ad_fetch || act_wr)
				dq_out <= wf_head.data;
			else if (ad_addr)
				dq_out <= chan_addr;
		end
	end
	assign o_addon_data      = !i_address_out_enable_n ? chan_addr : dq_out;
	assign o_addon_data_oe_n = i_address_out_enable_n && dq_oe_n;

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	always_comb begin
		rd_mux = '0;
		if (i_avs_address < `PTC_A_MASK)
			rd_mux = base[i_avs_address[`PTC_REG_SEL]];
		else if (i_avs_address < `PTC_A_CTRL)
			rd_mux = mask[i_avs_address[`PTC_REG_SEL]];
		else if (i_avs_address == `PTC_A_CTRL)
			rd_mux = {20'h0, ctrl};
		else if (i_avs_address == `PTC_A_STAT)
			rd_mux = {20'h0, passive, st, 4'(rf_count), 4'(wf_count)};
	end
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= '0;
			base              <= '{default: '0};
			mask              <= '{default: '0};
			ctrl              <= '0;
		end else if (i_clk_en) begin
			if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
				o_avs_waitrequest <= 1'b0;
				o_avs_readdata    <= rd_mux;
			end else
				o_avs_waitrequest <= 1'b1;
			if (i_avs_write && !o_avs_waitrequest) begin
				if (i_avs_address < `PTC_A_MASK)
					base[i_avs_address[`PTC_REG_SEL]] <= i_avs_writedata;
				else if (i_avs_address < `PTC_A_CTRL)
					mask[i_avs_address[`PTC_REG_SEL]] <= i_avs_writedata;
				else if (i_avs_address == `PTC_A_CTRL)
					ctrl <= i_avs_writedata[11:0];
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_flush_state: assert property (i_clk_en && go_flush |=> st == PTC_FLUSH)
		else $error("flush state skipped");
	a_trdy_has_data: assert property ($fell(o_pci.trdy_n) && st == PTC_RD |-> $past(rf_count) != '0)
		else $error("read TRDY without data");
	a_wr_room: assert property (wr_done |-> wf_count != FULL)
		else $error("write FIFO overrun");
	a_first_retry: assert property (i_clk_en && st == PTC_RD && first && o_pci.trdy_n && rf_count == '0 &&
		wait_cnt == 5'h0f |=> st == PTC_STOP)
		else $error("no retry after first wait");
	a_next_disc: assert property (i_clk_en && st == PTC_RD && !first && o_pci.trdy_n && rf_count == '0 &&
		wait_cnt == 5'h07 |=> st == PTC_STOP)
		else $error("no disconnect after wait");
	a_addr_step: assert property (i_clk_en && rd_done |=> chan_addr == $past(chan_addr) + 32'h4)
		else $error("address not stepped");
	a_attn_write: assert property (i_clk_en && wf_count != '0 |=> !o_status.attention_n && o_status.direction)
		else $error("write not signalled");
	a_addr_async: assert property (!i_address_out_enable_n |-> o_addon_data == chan_addr && !o_addon_data_oe_n)
		else $error("address not driven");
	a_near_end: assert property (near_end && st == PTC_RD |=> fetch_left <= $past(fetch_left))
		else $error("read-ahead near region end");
	a_region_out: assert property (i_clk_en && accept ##1 i_clk_en |=> o_status.region == $past(hit_num, 2))
		else $error("region number wrong");
	c_burst_write: cover property (wr_done ##1 wr_done);
	c_read_retry: cover property (st == PTC_STOP && first);
	c_read_burst: cover property (rd_done ##[1:4] rd_done);
endmodule

// File: verilog/ptc_defines.svh
// Constants for the PCI target pass-through channel.
// Assumes inclusion by the channel top file only.
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH
`define PTC_A_BASE 6'h00
`define PTC_A_MASK 6'h10
`define PTC_A_CTRL 6'h20
`define PTC_A_STAT 6'h24
`define PTC_REG_SEL 3:2
`define PTC_CMD_IO 3'h1
`define PTC_CMD_MEM 3'h3
`define PTC_IDX_ADDR 5'h0a
`define PTC_IDX_DATA 5'h0b
`define PTC_STEP 32'h0000_0004
`define PTC_NEAR_END 32'h0000_0020
`define PTC_FIRST_WAIT 5'h10
`define PTC_NEXT_WAIT 5'h08
`define PTC_STRAP_WAIT 3'h6
`define PTC_SYNC_RST 43'h3c1_0000_0000
`endif

// File: verilog/ptc_pkg.sv
// Types shared by the pass-through channel.
// Assumes nothing beyond the constants header.
package ptc_pkg;
	typedef enum logic [2:0] {PTC_IDLE, PTC_FLUSH, PTC_WR, PTC_RD, PTC_STOP, PTC_TURN} ptc_state_t;
	typedef struct packed {
		logic        frame_n;
		logic        irdy_n;
		logic [3:0]  cbe_n;
		logic [31:0] ad;
	} ptc_pci_in_t;
	typedef struct packed {
		logic        devsel_n;
		logic        trdy_n;
		logic        stop_n;
		logic        ctl_oe_n;
		logic        ad_oe_n;
		logic [31:0] ad;
	} ptc_pci_out_t;
	typedef struct packed {
		logic       attention_n;
		logic       burst_n;
		logic       direction;
		logic [1:0] region;
		logic [3:0] byte_valid_n;
		logic       strobe_n;
	} ptc_status_t;
	typedef struct packed {
		logic        lclk;
		logic        strap;
		logic        cs_n;
		logic        fetch_n;
		logic        store_n;
		logic [4:0]  idx;
		logic        done_n;
		logic [31:0] data;
	} ptc_addon_in_t;
	typedef struct packed {
		logic [3:0]  be_n;
		logic [31:0] data;
	} ptc_wentry_t;
endpackage

// File: verif/ptc_addon_model.sv
// Add-on logic model for the pass-through channel, passive mode.
// Assumes the channel samples these pins with its own clock.
module ptc_addon_model (
	// Channel outputs
	input  wire ptc_pkg::ptc_status_t i_status,
	input  wire logic [31:0]          i_addon_data,
	input  wire logic                 i_addon_data_oe_n,
	// Add-on pins
	output logic                      o_local_clock,
	output logic                      o_strap,
	output logic                      o_chip_select_n,
	output logic                      o_fetch_n,
	output logic                      o_store_n,
	output logic [4:0]                o_reg_index,
	output logic                      o_transfer_done_n,
	output logic [31:0]               o_data,
	output logic                      o_address_out_enable_n,
	// Observation
	output logic [31:0]               o_fetched,
	output int                        o_n_fetch
);
	timeunit 1ns;
	timeprecision 1ns;
	import ptc_pkg::*;
	int st;

	initial begin
		o_local_clock = 1'b0;
		o_strap = 1'b1;
		o_chip_select_n = 1'b1;
		o_fetch_n = 1'b1;
		o_store_n = 1'b1;
		o_reg_index = 5'h00;
		o_transfer_done_n = 1'b1;
		o_data = 32'hffff_ffff;
		o_address_out_enable_n = 1'b1;
		o_fetched = 32'h0;
		o_n_fetch = 0;
		st = 0;
	end

	always #400 o_local_clock = ~o_local_clock;

	// ----------------------------------------
	// Strobes, changed only after local edges
	// ----------------------------------------
	always @(posedge o_local_clock) begin
		case (st)
			0: begin
				if (i_status.attention_n === 1'b0 && i_status.direction === 1'b1) begin
					o_chip_select_n <= 1'b0;
					o_fetch_n <= 1'b0;
					o_reg_index <= 5'h0b;
					st <= 1;
				end else if (i_status.attention_n === 1'b0 && i_status.direction === 1'b0) begin
					o_address_out_enable_n <= 1'b0;
					st <= 3;
				end
			end
			1: begin
				o_chip_select_n <= 1'b1;
				o_fetch_n <= 1'b1;
				st <= 2;
			end
			2: begin
				if (i_addon_data_oe_n === 1'b0) begin
					o_fetched <= i_addon_data;
					o_n_fetch <= o_n_fetch + 1;
				end
				st <= 4;
			end
			3: begin
				o_address_out_enable_n <= 1'b1;
				o_chip_select_n <= 1'b0;
				o_store_n <= 1'b0;
				o_reg_index <= 5'h0b;
				o_data <= i_addon_data ^ 32'h5a5a_5a5a;
				st <= 5;
			end
			5: begin
				o_chip_select_n <= 1'b1;
				o_store_n <= 1'b1;
				o_data <= ~o_data;
				st <= 4;
			end
			4: st <= 6;
			default: st <= 0;
		endcase
	end
endmodule

// File: verif/testbench.sv
// Self-checking bench: register bus, PCI initiator tasks, add-on model.
// Assumes the add-on model runs the channel in passive mode.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import ptc_pkg::*;
	logic         i_clock = 1'b0;
	logic         i_rst_n = 1'b0;
	logic [5:0]   avs_address = 6'h00;
	logic         avs_read = 1'b0;
	logic         avs_write = 1'b0;
	logic [31:0]  avs_writedata = 32'h0;
	logic [31:0]  avs_readdata;
	logic         avs_waitrequest;
	ptc_pci_in_t  pci_in = '{frame_n: 1'b1, irdy_n: 1'b1, cbe_n: 4'hf, ad: 32'h0};
	ptc_pci_out_t pci_out;
	ptc_status_t  status;
	logic         lclk, strap, cs_n, fetch_n, store_n, done_n, aoe_n, ao_oe_n;
	logic [4:0]   idx;
	logic [31:0]  ao_in, ao_out, fetched, rd, a;
	int           n_fetch, res, lat, n, k;
	int           n_mismatch = 0;
	int           checks_done = 0;
	logic [5:0]   ra [5] = '{6'h00, 6'h10, 6'h04, 6'h14, 6'h20};
	logic [31:0]  rv [5] = '{32'h1000_0000, 32'h0000_0fff, 32'h2000_0000, 32'h0000_0fff, 32'h0000_0300};

	always #50 i_clock = ~i_clock;

	ptc_channel #(.DEPTH(8)) DUT (
		.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
		.i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
		.i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
		.i_pci(pci_in), .o_pci(pci_out), .i_local_clock(lclk), .i_operating_mode_strap(strap),
		.i_chip_select_n(cs_n), .i_fetch_n(fetch_n), .i_store_n(store_n), .i_reg_index(idx),
		.i_transfer_done_n(done_n), .i_addon_data(ao_in), .i_address_out_enable_n(aoe_n),
		.o_status(status), .o_addon_data(ao_out), .o_addon_data_oe_n(ao_oe_n)
	);

	ptc_addon_model addon (
		.i_status(status), .i_addon_data(ao_out), .i_addon_data_oe_n(ao_oe_n),
		.o_local_clock(lclk), .o_strap(strap), .o_chip_select_n(cs_n), .o_fetch_n(fetch_n),
		.o_store_n(store_n), .o_reg_index(idx), .o_transfer_done_n(done_n), .o_data(ao_in),
		.o_address_out_enable_n(aoe_n), .o_fetched(fetched), .o_n_fetch(n_fetch)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
		checks_done++;
		if (seen !== expected) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, expected, seen);
		end
	endtask

	task automatic avs(input logic wr, input logic [5:0] adr, input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clock);
		avs_address <= adr;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge i_clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Result: 0 data moved, 1 stopped without data, 2 not claimed
	task automatic pci(input logic [3:0] cmd, input logic [31:0] adr, input logic [3:0] be, input logic [31:0] d,
			output logic [31:0] q, output int r, output int l);
		@(posedge i_clock);
		pci_in <= '{frame_n: 1'b0, irdy_n: 1'b1, cbe_n: cmd, ad: adr};
		@(posedge i_clock);
		pci_in <= '{frame_n: 1'b1, irdy_n: 1'b0, cbe_n: be, ad: cmd[0] ? d : ~adr};
		l = 0;
		r = 2;
		while (l < 30 && r == 2) begin
			@(posedge i_clock);
			if (pci_out.trdy_n === 1'b0) r = 0;
			else if (pci_out.stop_n === 1'b0) r = 1;
			l++;
		end
		q = pci_out.ad;
		pci_in <= '{frame_n: 1'b1, irdy_n: 1'b1, cbe_n: 4'hf, ad: ~d};
		repeat (4) @(posedge i_clock);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (19) @(posedge i_clock);
		check("devsel in reset", 32'(pci_out.devsel_n), 32'h1);
		check("attention in reset", 32'(status.attention_n), 32'h1);
		@(posedge i_clock);
		i_rst_n <= 1'b1;
		for (k = 0; k < 5; k++) avs(1'b1, ra[k], rv[k], rd);
		for (k = 0; k < 5; k++) begin
			avs(1'b0, ra[k], 32'h0, rd);
			check("region register", rd, rv[k]);
		end
		avs(1'b0, 6'h28, 32'h0, rd);
		check("unmapped read", rd, 32'h0);
		avs(1'b0, 6'h24, 32'h0, rd);
		check("passive strap", 32'(rd[11]), 32'h1);
		pci(4'h7, 32'h3000_0000, 4'h0, 32'h0, rd, res, lat);
		check("no claim outside", 32'(res), 32'h2);
		for (k = 0; k < 2; k++) begin
			a = (k == 0) ? 32'h1000_0008 : 32'h2000_0010;
			pci(4'h7, a, (k == 0) ? 4'h2 : 4'h0, 32'hc0de_0000 + k, rd, res, lat);
			check("write accepted", 32'(res), 32'h0);
			check("write at once", 32'(lat), 32'h1);
			check("attention", 32'(status.attention_n), 32'h0);
			check("direction", 32'(status.direction), 32'h1);
			check("region", 32'(status.region), k);
			check("byte valid", 32'(status.byte_valid_n), (k == 0) ? 32'h2 : 32'h0);
			check("burst flag", 32'(status.burst_n), 32'h1);
			check("active strobe", 32'(status.strobe_n), 32'h1);
			check("bus released", 32'(pci_out.ctl_oe_n), 32'h1);
			n = 0;
			while (n_fetch == k && n < 300) begin
				@(posedge i_clock);
				n++;
			end
			check("fetched data", fetched, 32'hc0de_0000 + k);
			repeat (4) @(posedge i_clock);
			check("attention clear", 32'(status.attention_n), 32'h1);
		end
		for (k = 0; k < 3; k++) begin
			a = (k == 0) ? 32'h1000_0020 : (k == 1) ? 32'h1000_0100 : 32'h1000_0ff0;
			res = 1;
			n = 0;
			while (res != 0 && n < 8) begin
				pci(4'h6, a, 4'h0, 32'h0, rd, res, lat);
				n++;
			end
			check("read served", 32'(res), 32'h0);
			check("first read retried", 32'(n > 1), 32'h1);
			check("read data", rd, a ^ 32'h5a5a_5a5a);
		end
		final_report;
	end

	initial begin
		#3_000_000;
		n_mismatch++;
		final_report;
	end
endmodule
